// ===== core/tmr_pkg.sv
// Overview of operation
// - Each legacy timer count is 16 bits as separate low and high bytes.
// - Each legacy timer has its own two-bit mode field in the mode register.
// - 13-bit mode: high byte holds upper eight bits, low byte bits 4..0.
// - 13-bit mode: low byte bits 7..5 hold whatever was written; software masks them.
// - 13-bit wrap to zero sets overflow flag; interrupt if enabled.
// - Counter-select set: count falling edges of the external count pin.
// - Counter-select clear: system clock if clock-select set, else prescaler.
// - Count only with run set and gate clear or gate input active.
// - Gate input active level comes from a per-timer polarity bit.
// - Setting run neither clears nor reloads; software preloads the count.
// - Second legacy timer mirrors the first with its own bits and inputs.
// - Third timer: two bytes; split bit picks 16-bit or dual 8-bit reload.
// - Third timer clock: system, system/12, or synchronized external/8.
// - Third timer 16-bit wrap loads reload pair and sets high overflow flag.
// - Third timer enable raises interrupt on every 16-bit overflow.
// - With low-byte enable also, low byte wrap raises interrupt too.
package tmr_pkg;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MODE = 4'h1;
	localparam logic [3:0] ADDR_A_LO = 4'h2;
	localparam logic [3:0] ADDR_A_HI = 4'h3;
	localparam logic [3:0] ADDR_B_LO = 4'h4;
	localparam logic [3:0] ADDR_B_HI = 4'h5;
	localparam logic [3:0] ADDR_CLKCTL = 4'h6;
	localparam logic [3:0] ADDR_EXTCFG = 4'h7;
	localparam logic [3:0] ADDR_IE = 4'h8;
	localparam logic [3:0] ADDR_T3_CTRL = 4'h9;
	localparam logic [3:0] ADDR_T3_LO = 4'hA;
	localparam logic [3:0] ADDR_T3_HI = 4'hB;
	localparam logic [3:0] ADDR_T3_RLL = 4'hC;
	localparam logic [3:0] ADDR_T3_RLH = 4'hD;
	localparam logic [3:0] ADDR_EIE = 4'hE;
	// Per legacy timer i: bit = base + stride * i
	localparam int RUN_BIT = 4;
	localparam int FLAG_BIT = 5;
	localparam int CTRL_STRIDE = 2;
	localparam int MODE_STRIDE = 4;
	localparam int CT_BIT = 2;
	localparam int GATE_BIT = 3;
	localparam int CLKSEL_BIT = 3;
	localparam int POL_BIT = 3;
	localparam int IE_BIT = 1;
	localparam int T3_SYSTEM_CLOCK_BIT = 6;
	localparam int T3_HFLAG = 7;
	localparam int T3_LFLAG = 6;
	localparam int T3_LIE = 5;
	localparam int T3_SPLIT = 3;
	localparam int T3_RUN = 2;
	localparam int T3_EXTCLK = 0;
	localparam int EIE_T3 = 7;
	localparam logic [5:0] PRESC_LAST = 6'h2F;
	localparam logic [2:0] EXT_DIV_LAST = 3'h7;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam int NSYNC = 5;
	typedef enum logic [1:0] {
		TMR_MODE_13 = 2'b00,
		TMR_MODE_16 = 2'b01,
		TMR_MODE_8R = 2'b10,
		TMR_MODE_OFF = 2'b11
	} tmr_mode_t;
	typedef enum logic [1:0] {
		TMR_SCALE_12 = 2'b00,
		TMR_SCALE_4 = 2'b01,
		TMR_SCALE_48 = 2'b10,
		TMR_SCALE_EXT8 = 2'b11
	} tmr_scale_t;
endpackage : tmr_pkg

// ===== core/tmr_timers.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module tmr_timers (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic timer_a_count_pin,
	input wire logic timer_b_count_pin,
	input wire logic ext_interrupt_a_input,
	input wire logic ext_interrupt_b_input,
	input wire logic ext_osc_clk,
	output logic timer_a_irq,
	output logic timer_b_irq,
	output logic third_timer_irq
);
	logic [7:0] ctrl_q, mode_q, clkctl_q, extcfg_q, ie_q, eie_q;
	logic [7:0] t3ctl_q, t3lo_q, t3hi_q, rll_q, rlh_q, rdata_q;
	logic [tmr_pkg::NSYNC-1:0] sync1_q, sync2_q, sync3_q, pins;
	logic [1:0] pin_fall, flag_set;
	logic [7:0] lo_v [2];
	logic [7:0] hi_v [2];
	logic [5:0] presc_q;
	logic [2:0] ext_div_q;
	logic tick4, tick12, tick48, ext_tick, presc_tick;
	logic ctrl_wr;

	assign pins = {ext_osc_clk, ext_interrupt_b_input, ext_interrupt_a_input,
		timer_b_count_pin, timer_a_count_pin};
	assign ctrl_wr = bus_wr && bus_addr == tmr_pkg::ADDR_CTRL;

	// First stage feeds only the second
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	assign pin_fall = sync3_q[1:0] & ~sync2_q[1:0];

	// Shared prescaler: one mod-48 counter yields /4, /12 and /48
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_q <= '0;
		end else begin
			presc_q <= (presc_q == tmr_pkg::PRESC_LAST) ? '0 : presc_q + 6'h01;
		end
	end
	assign tick4 = presc_q[1:0] == 2'h3;
	assign tick12 = presc_q == 6'h0B || presc_q == 6'h17 || presc_q == 6'h23
		|| presc_q == tmr_pkg::PRESC_LAST;
	assign tick48 = presc_q == tmr_pkg::PRESC_LAST;

	// External oscillator is sampled, so it must run well below ref_clk / 2
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_div_q <= '0;
		end else if (sync2_q[4] && !sync3_q[4]) begin
			ext_div_q <= ext_div_q + 3'h1;
		end
	end
	assign ext_tick = sync2_q[4] && !sync3_q[4] && ext_div_q == tmr_pkg::EXT_DIV_LAST;

	always_comb begin
		unique case (tmr_pkg::tmr_scale_t'(clkctl_q[1:0]))
			tmr_pkg::TMR_SCALE_12: presc_tick = tick12;
			tmr_pkg::TMR_SCALE_4: presc_tick = tick4;
			tmr_pkg::TMR_SCALE_48: presc_tick = tick48;
			tmr_pkg::TMR_SCALE_EXT8: presc_tick = ext_tick;
		endcase
	end

	for (genvar i = 0; i < 2; i++) begin : g_leg
		localparam logic [3:0] LO_A = (i == 0) ? tmr_pkg::ADDR_A_LO : tmr_pkg::ADDR_B_LO;
		localparam logic [3:0] HI_A = (i == 0) ? tmr_pkg::ADDR_A_HI : tmr_pkg::ADDR_B_HI;
		localparam int MB = tmr_pkg::MODE_STRIDE * i;
		localparam int FB = tmr_pkg::FLAG_BIT + tmr_pkg::CTRL_STRIDE * i;
		logic [7:0] lo_q, hi_q, lo_d, hi_d;
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0] c8;
		logic tick, run, ovf, flag_q;
		always_comb begin
			tick = mode_q[MB + tmr_pkg::CT_BIT] ? pin_fall[i]
				: (clkctl_q[tmr_pkg::CLKSEL_BIT + i] | presc_tick);
			run = ctrl_q[tmr_pkg::RUN_BIT + tmr_pkg::CTRL_STRIDE * i]
				&& (!mode_q[MB + tmr_pkg::GATE_BIT]
				|| sync2_q[2 + i] == extcfg_q[tmr_pkg::POL_BIT + MB]);
			c13 = {1'b0, hi_q, lo_q[4:0]} + 14'h0001;
			c16 = {1'b0, hi_q, lo_q} + 17'h00001;
			c8 = {1'b0, lo_q} + 9'h001;
			lo_d = lo_q;
			hi_d = hi_q;
			ovf = 1'b0;
			if (run && tick) begin
				unique case (tmr_pkg::tmr_mode_t'(mode_q[MB +: 2]))
					tmr_pkg::TMR_MODE_13: begin
						lo_d = {lo_q[7:5], c13[4:0]};
						hi_d = c13[12:5];
						ovf = c13[13];
					end
					tmr_pkg::TMR_MODE_16: begin
						{hi_d, lo_d} = c16[15:0];
						ovf = c16[16];
					end
					tmr_pkg::TMR_MODE_8R: begin
						lo_d = c8[8] ? hi_q : c8[7:0];
						ovf = c8[8];
					end
					tmr_pkg::TMR_MODE_OFF: begin
					end
				endcase
			end
		end
		// Writes win over counting; run bit never touches the count
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				lo_q <= '0;
				hi_q <= '0;
			end else begin
				lo_q <= (bus_wr && bus_addr == LO_A) ? bus_wdata : lo_d;
				hi_q <= (bus_wr && bus_addr == HI_A) ? bus_wdata : hi_d;
			end
		end
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				flag_q <= 1'b0;
			end else begin
				flag_q <= (ctrl_wr ? bus_wdata[FB] : flag_q) | ovf;
			end
		end
		assign lo_v[i] = lo_q;
		assign hi_v[i] = hi_q;
		assign flag_set[i] = flag_q;
	end

	// Third timer
	logic t3_tick, t3_run, t3_lwrap, t3_hwrap, split;
	logic [7:0] t3lo_d, t3hi_d;
	assign split = t3ctl_q[tmr_pkg::T3_SPLIT];
	assign t3_run = t3ctl_q[tmr_pkg::T3_RUN];
	always_comb begin
		if (clkctl_q[tmr_pkg::T3_SYSTEM_CLOCK_BIT]) begin
			t3_tick = 1'b1;
		end else begin
			t3_tick = t3ctl_q[tmr_pkg::T3_EXTCLK] ? ext_tick : tick12;
		end
		t3_lwrap = t3_run && t3_tick && t3lo_q == tmr_pkg::BYTE_ONES;
		t3_hwrap = t3_run && t3_tick && t3hi_q == tmr_pkg::BYTE_ONES && (split || t3_lwrap);
		t3lo_d = t3lo_q;
		t3hi_d = t3hi_q;
		if (t3_run && t3_tick) begin
			if (split) begin
				t3lo_d = t3_lwrap ? rll_q : t3lo_q + 8'h01;
				t3hi_d = t3_hwrap ? rlh_q : t3hi_q + 8'h01;
			end else if (t3_hwrap) begin
				t3lo_d = rll_q;
				t3hi_d = rlh_q;
			end else begin
				t3lo_d = t3lo_q + 8'h01;
				t3hi_d = t3_lwrap ? t3hi_q + 8'h01 : t3hi_q;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			t3lo_q <= '0;
			t3hi_q <= '0;
		end else begin
			t3lo_q <= (bus_wr && bus_addr == tmr_pkg::ADDR_T3_LO) ? bus_wdata : t3lo_d;
			t3hi_q <= (bus_wr && bus_addr == tmr_pkg::ADDR_T3_HI) ? bus_wdata : t3hi_d;
		end
	end

	// Flags: a hardware set in the clearing cycle survives
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			t3ctl_q <= '0;
		end else if (bus_wr && bus_addr == tmr_pkg::ADDR_T3_CTRL) begin
			t3ctl_q <= bus_wdata;
			t3ctl_q[tmr_pkg::T3_HFLAG] <= bus_wdata[tmr_pkg::T3_HFLAG] | t3_hwrap;
			t3ctl_q[tmr_pkg::T3_LFLAG] <= bus_wdata[tmr_pkg::T3_LFLAG] | t3_lwrap;
		end else begin
			t3ctl_q[tmr_pkg::T3_HFLAG] <= t3ctl_q[tmr_pkg::T3_HFLAG] | t3_hwrap;
			t3ctl_q[tmr_pkg::T3_LFLAG] <= t3ctl_q[tmr_pkg::T3_LFLAG] | t3_lwrap;
		end
	end

	// Plain configuration registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '0;
			mode_q <= '0;
			clkctl_q <= '0;
			extcfg_q <= '0;
			ie_q <= '0;
			eie_q <= '0;
			rll_q <= '0;
			rlh_q <= '0;
		end else if (bus_wr) begin
			unique case (bus_addr)
				tmr_pkg::ADDR_CTRL: ctrl_q <= bus_wdata;
				tmr_pkg::ADDR_MODE: mode_q <= bus_wdata;
				tmr_pkg::ADDR_CLKCTL: clkctl_q <= bus_wdata;
				tmr_pkg::ADDR_EXTCFG: extcfg_q <= bus_wdata;
				tmr_pkg::ADDR_IE: ie_q <= bus_wdata;
				tmr_pkg::ADDR_EIE: eie_q <= bus_wdata;
				tmr_pkg::ADDR_T3_RLL: rll_q <= bus_wdata;
				tmr_pkg::ADDR_T3_RLH: rlh_q <= bus_wdata;
				default: begin
				end
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (!bus_rd) begin
			rdata_q <= '0;
		end else begin
			unique case (bus_addr)
				tmr_pkg::ADDR_CTRL: rdata_q <= {flag_set[1], ctrl_q[6], flag_set[0], ctrl_q[4:0]};
				tmr_pkg::ADDR_MODE: rdata_q <= mode_q;
				tmr_pkg::ADDR_A_LO: rdata_q <= lo_v[0];
				tmr_pkg::ADDR_A_HI: rdata_q <= hi_v[0];
				tmr_pkg::ADDR_B_LO: rdata_q <= lo_v[1];
				tmr_pkg::ADDR_B_HI: rdata_q <= hi_v[1];
				tmr_pkg::ADDR_CLKCTL: rdata_q <= clkctl_q;
				tmr_pkg::ADDR_EXTCFG: rdata_q <= extcfg_q;
				tmr_pkg::ADDR_IE: rdata_q <= ie_q;
				tmr_pkg::ADDR_T3_CTRL: rdata_q <= t3ctl_q;
				tmr_pkg::ADDR_T3_LO: rdata_q <= t3lo_q;
				tmr_pkg::ADDR_T3_HI: rdata_q <= t3hi_q;
				tmr_pkg::ADDR_T3_RLL: rdata_q <= rll_q;
				tmr_pkg::ADDR_T3_RLH: rdata_q <= rlh_q;
				tmr_pkg::ADDR_EIE: rdata_q <= eie_q;
				default: rdata_q <= '0;
			endcase
		end
	end
	assign bus_rdata = rdata_q;

	assign timer_a_irq = flag_set[0] && ie_q[tmr_pkg::IE_BIT];
	assign timer_b_irq = flag_set[1] && ie_q[tmr_pkg::IE_BIT + tmr_pkg::CTRL_STRIDE];
	assign third_timer_irq = eie_q[tmr_pkg::EIE_T3] && (t3ctl_q[tmr_pkg::T3_HFLAG]
		|| (t3ctl_q[tmr_pkg::T3_LIE] && t3ctl_q[tmr_pkg::T3_LFLAG]));

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_pin_fall;
		sync2_q[0] ##1 !sync2_q[0];
	endsequence
	sequence s_t3_wrap16;
		!split && t3_run && t3_tick && {t3hi_q, t3lo_q} == 16'hFFFF && !bus_wr;
	endsequence

	a_sync_fall_delay: assert property (pin_fall[0] |-> $past(timer_a_count_pin, 3)
		&& !$past(timer_a_count_pin, 2)) else $error("edge not from synced samples");
	a_ext_edge_count: assert property ((s_pin_fall ##0 (mode_q[2:0] == 3'h4
		&& g_leg[0].run && !bus_wr))
		|=> {hi_v[0], lo_v[0][4:0]} == $past({hi_v[0], lo_v[0][4:0]}) + 13'h0001)
		else $error("falling edge did not count");
	a_gate_blocks: assert property ((mode_q[3] && sync2_q[2] != extcfg_q[3] && !bus_wr)
		|=> $stable({hi_v[0], lo_v[0]})) else $error("gated timer counted");
	a_stop_holds: assert property ((!ctrl_q[4] && !bus_wr) |=> $stable({hi_v[0], lo_v[0]}))
		else $error("stopped timer counted");
	a_ovf13_flag: assert property ((g_leg[0].run && g_leg[0].tick && mode_q[1:0] == 2'b00
		&& hi_v[0] == 8'hFF && lo_v[0][4:0] == 5'h1F && !bus_wr)
		|=> flag_set[0] && hi_v[0] == 8'h00 && lo_v[0][4:0] == 5'h00
		&& (!ie_q[1] || timer_a_irq)) else $error("13-bit wrap missed flag");
	a_mode13_upper: assert property ((mode_q[1:0] == 2'b00 && !bus_wr)
		|=> $stable(lo_v[0][7:5])) else $error("13-bit upper bits moved");
	a_flag_sticky: assert property ((flag_set[0] && !ctrl_wr) |=> flag_set[0])
		else $error("flag cleared without write");
	a_count_write: assert property ((bus_wr && bus_addr == tmr_pkg::ADDR_A_LO)
		|=> lo_v[0] == $past(bus_wdata)) else $error("count write lost");
	a_t3_reload: assert property (s_t3_wrap16 |=> t3hi_q == $past(rlh_q)
		&& t3lo_q == $past(rll_q) && t3ctl_q[7]) else $error("reload missing");
	a_t3_irq: assert property (($rose(t3ctl_q[7]) && eie_q[7]) |-> third_timer_irq)
		else $error("third irq missing");
	a_rd_only_once: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data outside slot");
	a_b_stop_holds: assert property ((!ctrl_q[6] && !bus_wr)
		|=> $stable({hi_v[1], lo_v[1]})) else $error("stopped second timer counted");
	a_presc_hold: assert property ((g_leg[0].run && !mode_q[2] && !clkctl_q[3]
		&& !presc_tick && !bus_wr) |=> $stable({hi_v[0], lo_v[0]}))
		else $error("prescaled timer counted without tick");
	a_t3_split_hi: assert property ((split && t3_run && t3_tick && t3hi_q == 8'hFF
		&& !bus_wr) |=> t3hi_q == $past(rlh_q) && t3ctl_q[7])
		else $error("split high byte did not reload");
	a_t3_low_irq: assert property ((t3_lwrap && eie_q[7] && t3ctl_q[5] && !bus_wr)
		|=> third_timer_irq) else $error("low byte irq missing");
endmodule : tmr_timers

// ===== testbench/tmr_pin_model.sv
`timescale 1ns/1ps
module tmr_pin_model (
	input wire logic ref_clk,
	output logic timer_a_count_pin,
	output logic timer_b_count_pin,
	output logic ext_interrupt_a_input,
	output logic ext_interrupt_b_input,
	output logic ext_osc_clk
);
	logic [1:0] cnt_q = 2'h3;
	logic [1:0] gate_q = 2'h0;
	assign timer_a_count_pin = cnt_q[0];
	assign timer_b_count_pin = cnt_q[1];
	assign ext_interrupt_a_input = gate_q[0];
	assign ext_interrupt_b_input = gate_q[1];
	// Free-running oscillator, a sixth of ref_clk
	initial begin
		ext_osc_clk = 1'b0;
		forever begin
			repeat (3) @(posedge ref_clk);
			ext_osc_clk <= ~ext_osc_clk;
		end
	end
	// Two cycles low then two high, so no edge slips past the synchronizer
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			cnt_q[idx] <= 1'b0;
			repeat (2) @(posedge ref_clk);
			cnt_q[idx] <= 1'b1;
			@(posedge ref_clk);
		end
	endtask : pulse
	task automatic gate(input int idx, input logic lvl);
		@(posedge ref_clk);
		gate_q[idx] <= lvl;
	endtask : gate
endmodule : tmr_pin_model

// ===== testbench/dual_legacy_and_reload_timers_tb_top.sv
`timescale 1ns/1ps
module dual_legacy_and_reload_timers_tb_top;
	typedef struct {logic [7:0] e; logic [7:0] m;} tmr_note_t;
	logic ref_clk, rst_n, bus_wr, bus_rd;
	logic rd_seen = 1'b0;
	logic [3:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata, rv;
	logic ta, tb, ga, gb, osc, irq_a, irq_b, irq_3;
	int failures = 0;
	int samples_checked = 0;
	tmr_note_t notes[$];
	tmr_note_t cur;
	tmr_timers dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.timer_a_count_pin(ta), .timer_b_count_pin(tb), .ext_interrupt_a_input(ga),
		.ext_interrupt_b_input(gb), .ext_osc_clk(osc), .timer_a_irq(irq_a),
		.timer_b_irq(irq_b), .third_timer_irq(irq_3));
	tmr_pin_model pins (.ref_clk(ref_clk), .timer_a_count_pin(ta), .timer_b_count_pin(tb),
		.ext_interrupt_a_input(ga), .ext_interrupt_b_input(gb), .ext_osc_clk(osc));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		notes.push_back('{e & m, m});
		@(posedge ref_clk);
		bus_rd <= 1'b0;
	endtask : rd
	task automatic pause(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : pause
	task automatic finish_test();
		if (notes.size() != 0) failures++;
		$display("Checks %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk) rd_seen <= bus_rd;
	always @(negedge ref_clk) begin
		if (rd_seen === 1'b1 && notes.size() > 0) begin
			cur = notes.pop_front();
			check("bus_rdata", bus_rdata & cur.m, cur.e);
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 4'h0;
		bus_wdata = 8'h00;
		void'($urandom(32'hB3E6ED3F));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(4'hF, 8'hFF);
		for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
		for (int a = 2; a < 6; a++) begin
			rv = 8'($urandom);
			wr(4'(a), rv);
			rd(4'(a), rv);
		end
		// Timer A 13-bit on system clock, four ticks from wrap
		wr(tmr_pkg::ADDR_CLKCTL, 8'h08);
		wr(tmr_pkg::ADDR_IE, 8'h02);
		wr(tmr_pkg::ADDR_A_HI, 8'hFF);
		wr(tmr_pkg::ADDR_A_LO, 8'hFC);
		wr(tmr_pkg::ADDR_CTRL, 8'h10);
		pause(8);
		rd(tmr_pkg::ADDR_CTRL, 8'h30);
		rd(tmr_pkg::ADDR_A_HI, 8'h00);
		check("irq_a", 8'(irq_a), 8'h01);
		wr(tmr_pkg::ADDR_CTRL, 8'h00);
		pause(2);
		check("irq_a", 8'(irq_a), 8'h00);
		// Both timers count pins, gated, gates active high
		for (int a = 2; a < 6; a++) wr(4'(a), 8'h00);
		wr(tmr_pkg::ADDR_MODE, 8'hCC);
		wr(tmr_pkg::ADDR_EXTCFG, 8'h88);
		wr(tmr_pkg::ADDR_CTRL, 8'h50);
		pins.pulse(0, 3);
		pins.pulse(1, 3);
		pause(5);
		rd(tmr_pkg::ADDR_A_LO, 8'h00, 8'h1F);
		rd(tmr_pkg::ADDR_B_LO, 8'h00, 8'h1F);
		pins.gate(0, 1'b1);
		pins.gate(1, 1'b1);
		pause(4);
		pins.pulse(0, 3);
		pins.pulse(1, 5);
		pause(5);
		rd(tmr_pkg::ADDR_A_LO, 8'h03, 8'h1F);
		rd(tmr_pkg::ADDR_B_LO, 8'h05, 8'h1F);
		wr(tmr_pkg::ADDR_EXTCFG, 8'h00);
		pins.pulse(0, 2);
		pins.gate(0, 1'b0);
		pause(4);
		pins.pulse(0, 1);
		pause(5);
		rd(tmr_pkg::ADDR_A_LO, 8'h04, 8'h1F);
		wr(tmr_pkg::ADDR_MODE, 8'h44);
		wr(tmr_pkg::ADDR_CTRL, 8'h40);
		pins.pulse(0, 2);
		pins.pulse(1, 2);
		pause(5);
		rd(tmr_pkg::ADDR_A_LO, 8'h04, 8'h1F);
		rd(tmr_pkg::ADDR_B_LO, 8'h07, 8'h1F);
		// Third timer, 16-bit reload on system clock
		wr(tmr_pkg::ADDR_CLKCTL, 8'h40);
		wr(tmr_pkg::ADDR_EIE, 8'h80);
		wr(tmr_pkg::ADDR_T3_RLL, 8'h34);
		wr(tmr_pkg::ADDR_T3_RLH, 8'h12);
		wr(tmr_pkg::ADDR_T3_LO, 8'hFD);
		wr(tmr_pkg::ADDR_T3_HI, 8'hFF);
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h04);
		pause(4);
		rd(tmr_pkg::ADDR_T3_HI, 8'h12);
		rd(tmr_pkg::ADDR_T3_CTRL, 8'hC4);
		check("irq_3", 8'(irq_3), 8'h01);
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h00);
		pause(2);
		check("irq_3", 8'(irq_3), 8'h00);
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h40);
		pause(2);
		check("irq_3", 8'(irq_3), 8'h00);
		wr(tmr_pkg::ADDR_T3_LO, 8'hFD);
		wr(tmr_pkg::ADDR_T3_HI, 8'h00);
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h24);
		pause(5);
		rd(tmr_pkg::ADDR_T3_CTRL, 8'h64);
		rd(tmr_pkg::ADDR_T3_HI, 8'h01);
		check("irq_3", 8'(irq_3), 8'h01);
		// External source divided by 8: only two or three ticks in 100 cycles
		// Stop first, so no prescaler tick disturbs the preload
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h00);
		wr(tmr_pkg::ADDR_CLKCTL, 8'h00);
		wr(tmr_pkg::ADDR_T3_LO, 8'hFF);
		wr(tmr_pkg::ADDR_T3_HI, 8'hFF);
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h05);
		pause(100);
		rd(tmr_pkg::ADDR_T3_HI, 8'h12);
		rd(tmr_pkg::ADDR_T3_LO, 8'h34, 8'hFC);
		rd(tmr_pkg::ADDR_T3_CTRL, 8'h85, 8'hBF);
		// Third timer split: high byte wraps on its own
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h00);
		wr(tmr_pkg::ADDR_CLKCTL, 8'h41);
		wr(tmr_pkg::ADDR_T3_LO, 8'hFE);
		wr(tmr_pkg::ADDR_T3_HI, 8'hFD);
		wr(tmr_pkg::ADDR_T3_CTRL, 8'h0C);
		pause(4);
		rd(tmr_pkg::ADDR_T3_CTRL, 8'hCC);
		rd(tmr_pkg::ADDR_T3_HI, 8'h10, 8'hF0);
		// Timer A 16-bit from the /4 prescaler, about 76 ticks
		wr(tmr_pkg::ADDR_A_LO, 8'h00);
		wr(tmr_pkg::ADDR_A_HI, 8'h00);
		wr(tmr_pkg::ADDR_MODE, 8'h41);
		wr(tmr_pkg::ADDR_CTRL, 8'h50);
		pause(300);
		rd(tmr_pkg::ADDR_A_HI, 8'h00);
		rd(tmr_pkg::ADDR_A_LO, 8'h40, 8'hC0);
		wr(tmr_pkg::ADDR_IE, 8'h0A);
		check("irq_b", 8'(irq_b), 8'h00);
		wr(tmr_pkg::ADDR_CTRL, 8'h80);
		pause(2);
		check("irq_b", 8'(irq_b), 8'h01);
		finish_test();
	end
endmodule : dual_legacy_and_reload_timers_tb_top
